// File: design/dba_pkg.sv
package dba_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] IO_LO = 16'h0000;
	localparam logic [15:0] IO_HI = 16'h007F;
	localparam logic [15:0] XIO_LO = 16'h0F80;
	localparam logic [15:0] XIO_HI = 16'h0FFF;
	localparam logic [15:0] RAM_LO = 16'h0090;
	localparam logic [15:0] RAM_HI_BIG = 16'h047F;
	localparam logic [15:0] RAM_HI_SMALL = 16'h028F;
	localparam logic [15:0] GPR_LO = 16'h0100;
	localparam logic [15:0] GPR_HI = 16'h01FF;
	localparam logic [15:0] FLASH_LO = 16'h8000;
	localparam logic [15:0] NVR_LO = 16'hFFBB;
	localparam logic [15:0] NVR_HI = 16'hFFBF;
	localparam logic [15:0] VEC_LO = 16'hFFC0;
	localparam logic [15:0] VEC_HI = 16'hFFFF;
	localparam logic [15:0] BANK_BASE = 16'h0080;
	localparam logic [7:0] DIR_FIXED_HI = 8'h7F;
	localparam logic [2:0] BANK_SMALL_LAST = 3'h4;

	localparam logic [4:0] REG_SYSCFG = 5'h00;
	localparam logic [4:0] REG_BANK = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_FAULT = 5'h0C;

	localparam int CFG_DRV_BIT = 0;
	localparam int CFG_FUNC_BIT = 1;
	localparam int CFG_GPIO_OUT_BIT = 2;
	localparam int CFG_GPIO_DIR_BIT = 3;
	localparam int BANK_PTR_LSB = 0;
	localparam int BANK_SMALL_BIT = 8;
	localparam int STAT_PIN_BIT = 0;
	localparam int STAT_EXTRST_BIT = 1;
	localparam int STAT_ADDR_LSB = 16;
	localparam int FAULT_RANGE_BIT = 0;

	localparam logic CFG_DRV_RST = 1'b1;
	localparam logic CFG_FUNC_RST = 1'b1;
	localparam logic CFG_GPIO_OUT_RST = 1'b0;
	localparam logic CFG_GPIO_DIR_RST = 1'b0;
	localparam logic [2:0] BANK_PTR_RST = 3'h0;
	localparam logic BANK_SMALL_RST = 1'b0;

	typedef enum logic [0:0] {
		DBA_BUS_IDLE = 1'b0,
		DBA_BUS_ACK = 1'b1
	} dba_bus_state_t;
endpackage

// File: design/dba_bank_xlate.sv
`timescale 1ns/10ps
module dba_bank_xlate (
	input wire logic [7:0] operand_i,
	input wire logic [2:0] bank_ptr_i,
	input wire logic small_ram_i,
	output logic [15:0] phys_o,
	output logic range_err_o
);
	always_comb
	begin
		phys_o = {8'h00, operand_i};
		range_err_o = 1'b0;
		// Fixed window ignores the pointer; pointer zero leaves the upper half untouched
		if (operand_i > dba_pkg::DIR_FIXED_HI && bank_ptr_i != 3'h0)
		begin
			phys_o = dba_pkg::BANK_BASE + {6'h00, bank_ptr_i, 7'h00} + {9'h000, operand_i[6:0]};
			if (small_ram_i && phys_o > dba_pkg::RAM_HI_SMALL)
				range_err_o = 1'b1;
		end
	end
endmodule // dba_bank_xlate

// File: design/dba_region_decode.sv
`timescale 1ns/10ps
module dba_region_decode (
	input wire logic [15:0] addr_i,
	input wire logic small_ram_i,
	output logic sel_io_o,
	output logic sel_xio_o,
	output logic sel_ram_o,
	output logic sel_gpr_o,
	output logic sel_flash_o,
	output logic sel_nvr_o,
	output logic sel_vec_o,
	output logic sel_none_o
);
	function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	logic [15:0] ram_hi;

	always_comb
	begin
		ram_hi = small_ram_i ? dba_pkg::RAM_HI_SMALL : dba_pkg::RAM_HI_BIG;
		sel_io_o = in_span(addr_i, dba_pkg::IO_LO, dba_pkg::IO_HI);
		sel_xio_o = in_span(addr_i, dba_pkg::XIO_LO, dba_pkg::XIO_HI);
		sel_gpr_o = in_span(addr_i, dba_pkg::GPR_LO, dba_pkg::GPR_HI);
		sel_ram_o = in_span(addr_i, dba_pkg::RAM_LO, ram_hi) && !sel_gpr_o;
		sel_nvr_o = in_span(addr_i, dba_pkg::NVR_LO, dba_pkg::NVR_HI);
		sel_vec_o = in_span(addr_i, dba_pkg::VEC_LO, dba_pkg::VEC_HI);
		sel_flash_o = in_span(addr_i, dba_pkg::FLASH_LO, dba_pkg::NVR_LO - 16'h0001);
		// Gaps in the 64 KB map land here so exactly one select is always high
		sel_none_o = !(sel_io_o || sel_xio_o || sel_gpr_o || sel_ram_o || sel_nvr_o
			|| sel_vec_o || sel_flash_o);
	end
endmodule // dba_region_decode

// File: design/dba_map_top.sv
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module dba_map_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [7:0] cpu_operand_i,
	input wire logic cpu_direct_i,
	output logic [15:0] phys_addr_o,
	output logic sel_io_o,
	output logic sel_xio_o,
	output logic sel_ram_o,
	output logic sel_gpr_o,
	output logic sel_flash_o,
	output logic sel_nvr_o,
	output logic sel_vec_o,
	output logic sel_none_o,
	output logic [4:0] vec_slot_o,
	output logic range_err_o,
	input wire logic internal_reset_i,
	input wire logic shared_reset_port_pin_i,
	output logic shared_reset_port_pin_o,
	output logic shared_reset_port_pin_oe_o,
	output logic ext_reset_req_o,
	output logic gpio_in_o
);
	dba_pkg::dba_bus_state_t bus_state;
	logic reset_pin_drive_enable;
	logic reset_pin_function_select;
	logic gpio_out;
	logic gpio_dir;
	logic [2:0] direct_bank_pointer;
	logic small_ram;
	logic range_fault;
	logic [15:0] next_phys;
	logic xlate_err;
	logic next_io;
	logic next_xio;
	logic next_ram;
	logic next_gpr;
	logic next_flash;
	logic next_nvr;
	logic next_vec;
	logic next_none;
	logic next_err;
	logic [31:0] next_rdata;
	logic [15:0] bank_phys;
	logic bus_req;
	logic bus_wr_take;

	assign bus_req = avs_read_i || avs_write_i;
	assign bus_wr_take = (bus_state == dba_pkg::DBA_BUS_ACK) && avs_write_i;

	dba_bank_xlate u_xlate (
		.operand_i(cpu_operand_i),
		.bank_ptr_i(direct_bank_pointer),
		.small_ram_i(small_ram),
		.phys_o(bank_phys),
		.range_err_o(xlate_err)
	);

	// Full-width accesses bypass the bank pointer entirely
	assign next_phys = cpu_direct_i ? bank_phys : cpu_addr_i;
	assign next_err = cpu_direct_i && xlate_err;

	dba_region_decode u_decode (
		.addr_i(next_phys),
		.small_ram_i(small_ram),
		.sel_io_o(next_io),
		.sel_xio_o(next_xio),
		.sel_ram_o(next_ram),
		.sel_gpr_o(next_gpr),
		.sel_flash_o(next_flash),
		.sel_nvr_o(next_nvr),
		.sel_vec_o(next_vec),
		.sel_none_o(next_none)
	);

	// Registered so every select is glitch free; the CPU samples one edge later
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			phys_addr_o <= 16'h0000;
			sel_io_o <= 1'b0;
			sel_xio_o <= 1'b0;
			sel_ram_o <= 1'b0;
			sel_gpr_o <= 1'b0;
			sel_flash_o <= 1'b0;
			sel_nvr_o <= 1'b0;
			sel_vec_o <= 1'b0;
			sel_none_o <= 1'b1;
			range_err_o <= 1'b0;
		end
		else
		begin
			phys_addr_o <= next_phys;
			sel_io_o <= next_io && !(cpu_direct_i && next_err);
			sel_xio_o <= next_xio && !cpu_direct_i;
			sel_ram_o <= next_ram && !next_err;
			sel_gpr_o <= next_gpr && !next_err;
			sel_flash_o <= next_flash && !cpu_direct_i;
			sel_nvr_o <= next_nvr && !cpu_direct_i;
			sel_vec_o <= next_vec && !cpu_direct_i;
			sel_none_o <= next_none || next_err || (cpu_direct_i
				&& (next_xio || next_flash || next_nvr || next_vec));
			range_err_o <= next_err;
		end
	end

	// Word slot of the vector entry; the entry itself is read as data from flash
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			vec_slot_o <= 5'h00;
		else
			vec_slot_o <= next_phys[5:1];
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			bus_state <= dba_pkg::DBA_BUS_IDLE;
		else
		begin
			case (bus_state)
				dba_pkg::DBA_BUS_IDLE:
					if (bus_req)
						bus_state <= dba_pkg::DBA_BUS_ACK;
				dba_pkg::DBA_BUS_ACK:
					bus_state <= dba_pkg::DBA_BUS_IDLE;
				default:
					bus_state <= dba_pkg::DBA_BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !((bus_state == dba_pkg::DBA_BUS_IDLE) && bus_req);
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (avs_address_i)
			dba_pkg::REG_SYSCFG:
			begin
				next_rdata[dba_pkg::CFG_DRV_BIT] = reset_pin_drive_enable;
				next_rdata[dba_pkg::CFG_FUNC_BIT] = reset_pin_function_select;
				next_rdata[dba_pkg::CFG_GPIO_OUT_BIT] = gpio_out;
				next_rdata[dba_pkg::CFG_GPIO_DIR_BIT] = gpio_dir;
			end
			dba_pkg::REG_BANK:
			begin
				next_rdata[dba_pkg::BANK_PTR_LSB +: 3] = direct_bank_pointer;
				next_rdata[dba_pkg::BANK_SMALL_BIT] = small_ram;
			end
			dba_pkg::REG_STATUS:
			begin
				next_rdata[dba_pkg::STAT_PIN_BIT] = shared_reset_port_pin_i;
				next_rdata[dba_pkg::STAT_EXTRST_BIT] = ext_reset_req_o;
				next_rdata[dba_pkg::STAT_ADDR_LSB +: 16] = phys_addr_o;
			end
			dba_pkg::REG_FAULT:
				next_rdata[dba_pkg::FAULT_RANGE_BIT] = range_fault;
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			avs_readdata_o <= 32'h0000_0000;
		else if ((bus_state == dba_pkg::DBA_BUS_IDLE) && avs_read_i)
			avs_readdata_o <= next_rdata;
	end

	// Reset restores the pin to its reset role with output drive on
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			reset_pin_drive_enable <= dba_pkg::CFG_DRV_RST;
			reset_pin_function_select <= dba_pkg::CFG_FUNC_RST;
			gpio_out <= dba_pkg::CFG_GPIO_OUT_RST;
			gpio_dir <= dba_pkg::CFG_GPIO_DIR_RST;
		end
		else if (bus_wr_take && avs_address_i == dba_pkg::REG_SYSCFG && avs_byteenable_i[0])
		begin
			reset_pin_drive_enable <= avs_writedata_i[dba_pkg::CFG_DRV_BIT];
			reset_pin_function_select <= avs_writedata_i[dba_pkg::CFG_FUNC_BIT];
			gpio_out <= avs_writedata_i[dba_pkg::CFG_GPIO_OUT_BIT];
			gpio_dir <= avs_writedata_i[dba_pkg::CFG_GPIO_DIR_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			direct_bank_pointer <= dba_pkg::BANK_PTR_RST;
		else if (bus_wr_take && avs_address_i == dba_pkg::REG_BANK && avs_byteenable_i[0])
			direct_bank_pointer <= avs_writedata_i[dba_pkg::BANK_PTR_LSB +: 3];
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			small_ram <= dba_pkg::BANK_SMALL_RST;
		else if (bus_wr_take && avs_address_i == dba_pkg::REG_BANK && avs_byteenable_i[1])
			small_ram <= avs_writedata_i[dba_pkg::BANK_SMALL_BIT];
	end

	// Sticky: a new fault in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			range_fault <= 1'b0;
		else if (next_err)
			range_fault <= 1'b1;
		else if (bus_wr_take && avs_address_i == dba_pkg::REG_FAULT && avs_byteenable_i[0]
			&& avs_writedata_i[dba_pkg::FAULT_RANGE_BIT])
			range_fault <= 1'b0;
	end

	// Pin is open-drain style in reset role: it only ever pulls low
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			shared_reset_port_pin_o <= 1'b0;
			shared_reset_port_pin_oe_o <= 1'b0;
			ext_reset_req_o <= 1'b0;
			gpio_in_o <= 1'b0;
		end
		else if (reset_pin_function_select)
		begin
			shared_reset_port_pin_o <= 1'b0;
			shared_reset_port_pin_oe_o <= reset_pin_drive_enable && internal_reset_i;
			ext_reset_req_o <= !shared_reset_port_pin_i;
			gpio_in_o <= 1'b0;
		end
		else
		begin
			shared_reset_port_pin_o <= gpio_out;
			shared_reset_port_pin_oe_o <= gpio_dir;
			ext_reset_req_o <= 1'b0;
			gpio_in_o <= shared_reset_port_pin_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_req_idle;
		(bus_state == dba_pkg::DBA_BUS_IDLE) && (avs_read_i || avs_write_i);
	endsequence
	sequence s_one_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	chk_bus_ack_once: assert property (s_req_idle |=> s_one_ack)
		else $error("bus answer not a single cycle after request");
	chk_io_select: assert property (!cpu_direct_i && cpu_addr_i <= 16'h007F |=> sel_io_o)
		else $error("I/O area not selected");
	chk_xio_select: assert property (!cpu_direct_i && cpu_addr_i >= 16'h0F80
		&& cpu_addr_i <= 16'h0FFF |=> sel_xio_o && !sel_none_o)
		else $error("extended I/O area not selected");
	chk_vec_select: assert property (!cpu_direct_i && cpu_addr_i >= 16'hFFC0
		|=> sel_vec_o && vec_slot_o == $past(cpu_addr_i[5:1]))
		else $error("vector table not selected");
	chk_nvr_select: assert property (!cpu_direct_i && cpu_addr_i >= 16'hFFBB
		&& cpu_addr_i <= 16'hFFBF |=> sel_nvr_o)
		else $error("non-volatile data area not selected");
	chk_gpr_area: assert property (!cpu_direct_i && cpu_addr_i[15:8] == 8'h01
		|=> sel_gpr_o && !sel_ram_o)
		else $error("general register area not selected");
	chk_dir_fixed: assert property (cpu_direct_i && !cpu_operand_i[7]
		|=> phys_addr_o == {9'h000, $past(cpu_operand_i[6:0])})
		else $error("fixed direct window moved with bank pointer");
	chk_dir_unbanked: assert property (cpu_direct_i && direct_bank_pointer == 3'h0
		&& cpu_operand_i >= 8'h90 |=> sel_ram_o && phys_addr_o[15:8] == 8'h00)
		else $error("unbanked direct RAM not reached");
	chk_bank_map: assert property (cpu_direct_i && cpu_operand_i[7]
		&& direct_bank_pointer != 3'h0 |=> phys_addr_o == 16'h0080
		+ {6'h00, $past(direct_bank_pointer), 7'h00} + {9'h000, $past(cpu_operand_i[6:0])})
		else $error("banked direct address wrong");
	chk_small_limit: assert property (cpu_direct_i && small_ram
		&& direct_bank_pointer == 3'h4 && cpu_operand_i >= 8'h90
		|=> range_err_o && !sel_ram_o ##1 range_fault)
		else $error("small variant bank limit not enforced");
	chk_big_window: assert property (cpu_direct_i && !small_ram && cpu_operand_i[7]
		&& direct_bank_pointer != 3'h0 |=> !range_err_o)
		else $error("large window refused a banked access");
	chk_pin_drive: assert property (reset_pin_function_select && reset_pin_drive_enable
		&& internal_reset_i |=> shared_reset_port_pin_oe_o && !shared_reset_port_pin_o)
		else $error("internal reset not driven on pin");
	chk_gpio_mode: assert property (!reset_pin_function_select
		|=> !ext_reset_req_o && shared_reset_port_pin_oe_o == $past(gpio_dir))
		else $error("pin in I/O role still acts as reset");
	chk_one_hot: assert property ($onehot({sel_io_o, sel_xio_o, sel_ram_o, sel_gpr_o,
		sel_flash_o, sel_nvr_o, sel_vec_o, sel_none_o}))
		else $error("region selects not one-hot");

	// Direct operands never reach past 0x047F, so these areas stay full-address only
	chk_dir_no_flash: assert property (cpu_direct_i |=> !sel_xio_o && !sel_flash_o)
		else $error("direct access reached a full-address-only area");
	chk_flash_select: assert property (!cpu_direct_i && cpu_addr_i[15]
		&& cpu_addr_i < 16'hFFBB |=> sel_flash_o)
		else $error("program area not selected");
	chk_fault_sticky: assert property (next_err |=> range_fault)
		else $error("range fault flag not set");
	chk_reset_input: assert property (reset_pin_function_select
		&& !shared_reset_port_pin_i |=> ext_reset_req_o)
		else $error("low reset pin not reported");
	chk_drive_off: assert property (!reset_pin_drive_enable && reset_pin_function_select
		|=> !shared_reset_port_pin_oe_o)
		else $error("reset drive on while disabled");
endmodule // dba_map_top

// File: bench/dba_cpu_model.sv
`timescale 1ns/10ps
module dba_cpu_model (
	input wire logic clk_i,
	output logic [15:0] cpu_addr_o,
	output logic [7:0] cpu_operand_o,
	output logic cpu_direct_o
);
	initial
	begin
		cpu_addr_o = 16'h0000;
		cpu_operand_o = 8'h00;
		cpu_direct_o = 1'b0;
	end
	// The bus not in use is inverted so a stale value can never pass for a live one
	task automatic issue(input logic dir, input logic [15:0] a);
		@(posedge clk_i);
		cpu_direct_o <= dir;
		cpu_addr_o <= dir ? ~cpu_addr_o : a;
		cpu_operand_o <= dir ? a[7:0] : ~cpu_operand_o;
	endtask
endmodule // dba_cpu_model

// File: bench/direct_bank_address_map_tb.sv
`timescale 1ns/10ps
module direct_bank_address_map_tb;
	logic clk_i, srst_i, avs_read, avs_write, avs_waitrequest, cpu_direct, range_err;
	logic internal_reset, ext_low, pin_lvl, pin_o, pin_oe, ext_req, gpio_in;
	logic [4:0] avs_address, vec_slot;
	logic [3:0] avs_be;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] cpu_addr, phys, ep;
	logic [7:0] cpu_operand, sel;
	logic [7:0] ops [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
	logic [15:0] fa [18] = '{16'h0000, 16'h007F, 16'h0080, 16'h0090, 16'h00FF, 16'h0100,
		16'h01FF, 16'h0200, 16'h047F, 16'h0480, 16'h0F80, 16'h0FFF, 16'h8000, 16'hFFBA,
		16'hFFBB, 16'hFFBF, 16'hFFC0, 16'hFFFF};
	logic [9:0] pins [8] = '{10'h0D2, 10'h0EA, 10'h0C0, 10'h0A0, 10'h228, 10'h30D, 10'h010,
		10'h001};
	int miscompares, check_count;
	// Open-drain wire with a pull-up: low if anyone pulls it low
	assign pin_lvl = !((pin_oe && !pin_o) || ext_low);
	dba_cpu_model cpu_u (.clk_i(clk_i), .cpu_addr_o(cpu_addr), .cpu_operand_o(cpu_operand),
		.cpu_direct_o(cpu_direct));
	dba_map_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_byteenable_i(avs_be), .avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest), .cpu_addr_i(cpu_addr),
		.cpu_operand_i(cpu_operand), .cpu_direct_i(cpu_direct), .phys_addr_o(phys),
		.sel_io_o(sel[7]), .sel_xio_o(sel[6]), .sel_ram_o(sel[5]), .sel_gpr_o(sel[4]),
		.sel_flash_o(sel[3]), .sel_nvr_o(sel[2]), .sel_vec_o(sel[1]), .sel_none_o(sel[0]),
		.vec_slot_o(vec_slot), .range_err_o(range_err), .internal_reset_i(internal_reset),
		.shared_reset_port_pin_i(pin_lvl), .shared_reset_port_pin_o(pin_o),
		.shared_reset_port_pin_oe_o(pin_oe), .ext_reset_req_o(ext_req), .gpio_in_o(gpio_in));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		@(posedge clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_be <= be;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0)
		begin
			miscompares++;
			complete_run();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic probe(input logic dir, input logic [15:0] a, input logic [15:0] e,
		input logic sm);
		logic [7:0] es;
		logic err;
		es = exp_sel(e, sm, dir);
		err = dir && (e > (sm ? dba_pkg::RAM_HI_SMALL : dba_pkg::RAM_HI_BIG));
		cpu_u.issue(dir, a);
		@(posedge clk_i);
		#1;
		check("select", sel, es);
		check("range error", range_err, err);
		if (!err)
			check("physical", phys, e);
		if (es[1])
			check("vector slot", vec_slot, e[5:1]);
	endtask
	// Order: io xio ram gpr flash nvr vec none; flash top bound is the designer's choice
	function automatic logic [7:0] exp_sel(input logic [15:0] p, input logic sm,
		input logic dir);
		if (p <= dba_pkg::IO_HI)
			return 8'h80;
		if (p >= dba_pkg::GPR_LO && p <= dba_pkg::GPR_HI)
			return 8'h10;
		if (p >= dba_pkg::RAM_LO && p <= (sm ? dba_pkg::RAM_HI_SMALL : dba_pkg::RAM_HI_BIG))
			return 8'h20;
		if (dir)
			return 8'h01;
		if (p >= dba_pkg::XIO_LO && p <= dba_pkg::XIO_HI)
			return 8'h40;
		if (p >= dba_pkg::VEC_LO)
			return 8'h02;
		if (p >= dba_pkg::NVR_LO)
			return 8'h04;
		if (p >= dba_pkg::FLASH_LO)
			return 8'h08;
		return 8'h01;
	endfunction
	initial
	begin
		srst_i = 1'b1;
		{avs_read, avs_write, internal_reset, ext_low} = 4'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		avs_be = 4'hF;
		miscompares = 0;
		check_count = 0;
		repeat (8) @(posedge clk_i);
		#1;
		check("reset outputs", {sel, avs_waitrequest, pin_oe, ext_req}, 11'h00C);
		srst_i = 1'b0;
		bus(0, dba_pkg::REG_SYSCFG, 32'h0, 4'hF);
		check("syscfg", rd, 32'h0000_0003);
		bus(0, dba_pkg::REG_BANK, 32'h0, 4'hF);
		check("bank", rd, 32'h0000_0000);
		bus(1, 5'h10, 32'hFFFF_FFFF, 4'hF);
		bus(0, 5'h10, 32'h0, 4'hF);
		check("unmapped", rd, 32'h0000_0000);
		for (int i = 0; i < 18; i++)
			probe(0, fa[i], fa[i], 0);
		for (int p = 0; p < 8; p++)
		begin
			bus(1, dba_pkg::REG_BANK, 32'(p), 4'hF);
			for (int k = 0; k < 4; k++)
			begin
				ep = (ops[k][7] && p != 0) ? 16'h0080 + 16'(p) * 16'h0080 + ops[k][6:0] : ops[k];
				probe(1, ops[k], ep, 0);
			end
		end
		bus(1, dba_pkg::REG_BANK, 32'h0000_0000, 4'hF);
		probe(1, 16'h0090, 16'h0090, 0);
		// Park the CPU on a full address so the small-RAM switch cannot raise a fault
		cpu_u.issue(0, 16'h0000);
		bus(1, dba_pkg::REG_BANK, 32'h0000_0104, 4'h1);
		bus(0, dba_pkg::REG_BANK, 32'h0, 4'hF);
		check("bank lanes", rd, 32'h0000_0004);
		bus(1, dba_pkg::REG_BANK, 32'h0000_0104, 4'hF);
		probe(0, 16'h028F, 16'h028F, 1);
		probe(0, 16'h0290, 16'h0290, 1);
		probe(1, 16'h008F, 16'h028F, 1);
		bus(0, dba_pkg::REG_FAULT, 32'h0, 4'hF);
		check("fault clear", rd, 32'h0000_0000);
		probe(1, 16'h0090, 16'h0290, 1);
		bus(0, dba_pkg::REG_FAULT, 32'h0, 4'hF);
		check("fault set", rd, 32'h0000_0001);
		// A standing bad access would set the flag again in the clearing cycle
		cpu_u.issue(0, 16'h0000);
		bus(1, dba_pkg::REG_FAULT, 32'h0000_0001, 4'hF);
		bus(0, dba_pkg::REG_FAULT, 32'h0, 4'hF);
		check("fault cleared", rd, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			bus(1, dba_pkg::REG_SYSCFG, {28'h0, pins[i][9:6]}, 4'hF);
			@(posedge clk_i);
			internal_reset <= pins[i][5];
			ext_low <= pins[i][4];
			repeat (3) @(posedge clk_i);
			#1;
			check("pin", {pin_oe, pin_o, ext_req, gpio_in}, pins[i][3:0]);
		end
		cpu_u.issue(0, 16'hFFC0);
		bus(0, dba_pkg::REG_STATUS, 32'h0, 4'hF);
		check("status", rd, 32'hFFC0_0001);
		complete_run();
	end
endmodule // direct_bank_address_map_tb
